// [scpc_coil_model.sv]
// Behavioural solenoid coil: current follows the duty of the last carrier period.
`timescale 1ns/1ps
module scpc_coil_model #(
	parameter int PERIOD = 100
) (
	input  wire logic        clk_i,
	input  wire logic        pwm_i,
	input  wire logic [1:0]  gain_i,
	input  wire logic        short_i,
	output logic      [15:0] isense_o
);
	int phase = 0;
	int high = 0;
	initial isense_o = 16'h0000;
	// Current settles once a period, so the regulator sees one period of lag except while short_i forces the current.
	always @(posedge clk_i)
	begin
		high = high + (pwm_i ? 1 : 0);
		phase = phase + 1;
		if (phase >= PERIOD)
		begin
			isense_o <= 16'(high * 20 * gain_i);
			phase = 0;
			high = 0;
		end
		if (short_i)
			isense_o <= 16'h0BB8;
	end
endmodule : scpc_coil_model

// [scpc_core.sv]
// Solenoid current PWM controller with scaling, dither, derating, power reduction (switching mode only) and link window.
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "scpc_map.svh"
module scpc_core #(
	parameter int PWM_PERIOD = `SCPC_PWM_PERIOD,
	parameter int MS_TICKS   = `SCPC_CLK_HZ / 1000
) (
	// Clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  nrst_i,
	// Register port
	input  wire scpc_pkg::scpc_bus_t   bus_i,
	output logic [15:0]                rdata_o,
	// Command sources and sensors
	input  wire scpc_pkg::scpc_cmd_in_t cmd_i,
	input  wire logic [7:0]            temp_i,
	input  wire logic [15:0]           isense_i,
	input  wire logic                  enable_pin_i,
	input  wire logic                  button_i,
	input  wire logic                  link_activity_i,
	// Non-volatile store
	input  wire logic                  nv_valid_i,
	input  wire logic [15:0]           nv_rdata_i,
	output logic [3:0]                 nv_addr_o,
	output logic [15:0]                nv_wdata_o,
	output logic                       nv_we_o,
	// Outputs
	output logic                       pwm_o,
	output logic                       link_on_o,
	output logic                       error_o,
	output logic                       short_err_o
);
	////////////////////////////////////////////////////////////////////////////////
	logic       rs1;
	logic       rst_n;
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			rs1   <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rs1   <= 1'b1;
			rst_n <= rs1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Parameter registers.
	logic [7:0]  ctrl;
	logic [15:0] imin;
	logic [15:0] imax;
	logic [15:0] dith_amp;
	logic [15:0] dith_per;
	logic [15:0] red_time;
	logic [15:0] red_pct;
	logic [15:0] password;
	logic [15:0] link_tmo;
	logic        unlocked;
	logic        ack_req;
	logic [3:0]  restore_idx;
	logic        restoring;

	scpc_pkg::scpc_src_t src;
	wire         switching = ctrl[`SCPC_CTRL_SWITCHING];
	wire         pwm_mode  = ctrl[`SCPC_CTRL_PWM_MODE];
	wire         pred_en   = ctrl[`SCPC_CTRL_PRED_EN] & switching;
	assign src = scpc_pkg::scpc_src_t'(ctrl[2:0]);

	// While a password is set a parameter write needs an unlock, which lapses when the link closes.
	wire         wr_ok     = (password == 16'h0000) | unlocked;
	wire         is_param  = bus_i.addr <= `SCPC_ADR_RED_PCT || bus_i.addr == `SCPC_ADR_LINK_TMO
		|| bus_i.addr == `SCPC_ADR_PASSWORD;
	wire         pwr       = bus_i.wr & is_param & wr_ok & !restoring;
	wire         rst_load  = restoring & nv_valid_i;
	wire [3:0]   ld_adr    = rst_load ? restore_idx : bus_i.addr;
	wire [15:0]  ld_dat    = rst_load ? nv_rdata_i : bus_i.wdata;
	wire         ld        = rst_load | pwr;

	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl     <= 8'h00;
			imin     <= `SCPC_RST_IMIN;
			imax     <= `SCPC_RST_IMAX;
			dith_amp <= `SCPC_RST_DITH_AMP;
			dith_per <= `SCPC_RST_DITH_PER;
			red_time <= `SCPC_RST_RED_TIME;
			red_pct  <= `SCPC_RST_RED_PCT;
			password <= 16'h0000;
			link_tmo <= `SCPC_RST_LINK_TMO;
		end
		else if (ld)
		begin
			unique case (ld_adr)
				`SCPC_ADR_CTRL:     ctrl     <= ld_dat[7:0];
				`SCPC_ADR_IMIN:     imin     <= ld_dat;
				`SCPC_ADR_IMAX:     imax     <= ld_dat;
				`SCPC_ADR_DITH_AMP: dith_amp <= ld_dat;
				`SCPC_ADR_DITH_PER: dith_per <= ld_dat;
				`SCPC_ADR_RED_TIME: red_time <= ld_dat;
				`SCPC_ADR_RED_PCT:  red_pct  <= ld_dat;
				`SCPC_ADR_PASSWORD: password <= ld_dat;
				`SCPC_ADR_LINK_TMO: link_tmo <= ld_dat;
				default:            ;
			endcase
		end
	end

	// Restore walks the store once after reset, then mirrors every accepted parameter write.
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			restoring   <= 1'b1;
			restore_idx <= 4'h0;
			nv_we_o     <= 1'b0;
			nv_addr_o   <= 4'h0;
			nv_wdata_o  <= 16'h0000;
		end
		else
		begin
			nv_we_o <= pwr;
			if (pwr)
			begin
				nv_addr_o  <= bus_i.addr;
				nv_wdata_o <= bus_i.wdata;
			end
			else if (rst_load)
				nv_addr_o <= restore_idx + 4'h1;
			if (rst_load)
			begin
				restore_idx <= restore_idx + 4'h1;
				if (restore_idx == `SCPC_ADR_LINK_TMO)
					restoring <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
			unlocked <= 1'b0;
		else if (!link_on_o)
			unlocked <= 1'b0;
		else if (bus_i.wr && bus_i.addr == `SCPC_ADR_UNLOCK)
			unlocked <= (bus_i.wdata == password);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Millisecond tick and link window.
	logic [$clog2(MS_TICKS)-1:0] ms_cnt;
	logic        ms_tick;
	logic [15:0] idle_ms;
	logic        btn_q;
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ms_cnt  <= '0;
			ms_tick <= 1'b0;
		end
		else
		begin
			ms_tick <= (ms_cnt == ($clog2(MS_TICKS))'(MS_TICKS - 1));
			ms_cnt  <= (ms_cnt == ($clog2(MS_TICKS))'(MS_TICKS - 1)) ? '0 : ms_cnt + 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			link_on_o <= 1'b1;
			idle_ms   <= 16'h0000;
			btn_q     <= 1'b0;
		end
		else
		begin
			btn_q <= button_i;
			if (button_i && !btn_q)
			begin
				link_on_o <= 1'b1;
				idle_ms   <= 16'h0000;
			end
			else if (link_activity_i || bus_i.wr)
				idle_ms <= 16'h0000;
			else if (link_on_o && ms_tick)
			begin
				if (idle_ms >= link_tmo)
					link_on_o <= 1'b0;
				else
					idle_ms <= idle_ms + 16'h0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Command scaling to 0..1000 per mille.
	logic [15:0] cmd_pm;
	logic [15:0] src_val;
	logic [15:0] src_full;
	always_comb
	begin
		unique case (src)
			scpc_pkg::SRC_VOLT, scpc_pkg::SRC_CURR:
			begin
				src_val  = {4'h0, cmd_i.adc};
				src_full = 16'h0FFF;
			end
			scpc_pkg::SRC_DIG:
			begin
				src_val  = {15'h0000, cmd_i.adc[11]};
				src_full = 16'h0001;
			end
			scpc_pkg::SRC_FREQ:
			begin
				src_val  = cmd_i.freq;
				src_full = 16'h1388;
			end
			scpc_pkg::SRC_PWM:
			begin
				src_val  = cmd_i.duty;
				src_full = 16'hFFFF;
			end
			scpc_pkg::SRC_BUS:
			begin
				src_val  = cmd_i.bus_val;
				src_full = 16'hFFFF;
			end
			default:
			begin
				src_val  = 16'h0000;
				src_full = 16'h0001;
			end
		endcase
	end
	wire [31:0] scaled = (32'(src_val) * 32'd1000) / 32'(src_full);
	wire [15:0] next_cmd_pm = (scaled > 32'd1000) ? 16'd1000 : scaled[15:0];

	////////////////////////////////////////////////////////////////////////////////
	// Temperature, enable, error state.
	scpc_pkg::scpc_state_t state;
	wire        bus_var  = ctrl[`SCPC_CTRL_BUS_VAR];
	wire        enabled  = bus_var ? ctrl[`SCPC_CTRL_BUS_EN] : enable_pin_i;
	wire        too_hot  = temp_i > `SCPC_T_ERROR;
	wire        overcur  = isense_i > `SCPC_I_ABS_MAX;
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state       <= scpc_pkg::ST_OFF;
			error_o     <= 1'b0;
			short_err_o <= 1'b0;
			ack_req     <= 1'b0;
		end
		else
		begin
			ack_req <= bus_i.wr && bus_i.addr == `SCPC_ADR_ACK;
			unique case (state)
				scpc_pkg::ST_OFF, scpc_pkg::ST_RUN:
					if (too_hot || overcur)
					begin
						state       <= scpc_pkg::ST_ERROR;
						error_o     <= 1'b1;
						short_err_o <= overcur;
					end
					else
						state <= enabled ? scpc_pkg::ST_RUN : scpc_pkg::ST_OFF;
				scpc_pkg::ST_ERROR:
					if (ack_req && !too_hot && !overcur)
					begin
						state       <= scpc_pkg::ST_OFF;
						error_o     <= 1'b0;
						short_err_o <= 1'b0;
					end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Target current with derating, power reduction and dither.
	wire [15:0] t_over   = (temp_i > `SCPC_T_DERATE) ? 16'(temp_i - `SCPC_T_DERATE) : 16'h0000;
	wire [31:0] derate   = 32'(t_over) * 32'(`SCPC_DERATE_MA_PER_C);
	wire [15:0] imax_eff = (derate >= 32'(imax)) ? imin
		: ((imax - derate[15:0]) < imin ? imin : imax - derate[15:0]);
	wire [31:0] span     = 32'(imax_eff - imin) * 32'(cmd_pm);
	wire [15:0] itarget  = imin + 16'(span / 32'd1000);

	logic [15:0] on_ms;
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
			on_ms <= 16'h0000;
		else if (state != scpc_pkg::ST_RUN || cmd_pm == 16'h0000)
			on_ms <= 16'h0000;
		else if (ms_tick && on_ms < red_time)
			on_ms <= on_ms + 16'h0001;
	end
	wire        reducing = pred_en && on_ms >= red_time;
	wire [31:0] red_i    = (32'(itarget) * 32'(red_pct)) / 32'd100;
	wire [15:0] i_set    = reducing ? red_i[15:0] : itarget;

	// Dither is a square offset flipping only at carrier boundaries.
	logic [$clog2(PWM_PERIOD)-1:0] pcnt;
	logic [15:0] dper_cnt;
	logic        dith_hi;
	wire         carrier_end = pcnt == ($clog2(PWM_PERIOD))'(PWM_PERIOD - 1);
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pcnt     <= '0;
			dper_cnt <= 16'h0000;
			dith_hi  <= 1'b0;
			cmd_pm   <= 16'h0000;
		end
		else
		begin
			pcnt <= carrier_end ? '0 : pcnt + 1'b1;
			if (carrier_end)
			begin
				cmd_pm <= next_cmd_pm;
				if (dper_cnt + 16'h0001 >= dith_per)
				begin
					dper_cnt <= 16'h0000;
					dith_hi  <= !dith_hi;
				end
				else
					dper_cnt <= dper_cnt + 16'h0001;
			end
		end
	end
	wire [16:0] dith_up  = 17'(i_set) + 17'(dith_amp);
	wire [15:0] i_dith   = dith_hi ? (dith_up > 17'(imax) ? imax : dith_up[15:0])
		: (i_set > dith_amp ? i_set - dith_amp : 16'h0000);

	// Duty in clock ticks: closed loop steps one tick per period on measured current, switching runs open loop.
	logic [15:0] duty;
	wire [31:0] ol_duty  = (32'(i_dith) * 32'(PWM_PERIOD)) / 32'(`SCPC_I_ABS_MAX);
	wire [31:0] pm_duty  = (32'(cmd_pm) * 32'(PWM_PERIOD)) / 32'd1000;
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
			duty <= 16'h0000;
		else if (carrier_end)
		begin
			if (pwm_mode)
				duty <= 16'(pm_duty);
			else if (switching)
				duty <= 16'(ol_duty);
			else if (isense_i < i_dith && duty < 16'(PWM_PERIOD))
				duty <= duty + 16'h0001;
			else if (isense_i > i_dith && duty != 16'h0000)
				duty <= duty - 16'h0001;
		end
	end

	// The output starts only on a carrier boundary, so enabling mid-period never gives a runt pulse.
	logic run_gate;
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			run_gate <= 1'b0;
			pwm_o    <= 1'b0;
		end
		else
		begin
			run_gate <= (state == scpc_pkg::ST_RUN) && (run_gate || carrier_end);
			pwm_o    <= run_gate && (state == scpc_pkg::ST_RUN) && (16'(pcnt) < duty);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read port, data one cycle after the strobe.
	logic [15:0] rmux;
	always_comb
	begin
		unique case (bus_i.addr)
			`SCPC_ADR_CTRL:     rmux = {8'h00, ctrl};
			`SCPC_ADR_IMIN:     rmux = imin;
			`SCPC_ADR_IMAX:     rmux = imax;
			`SCPC_ADR_DITH_AMP: rmux = dith_amp;
			`SCPC_ADR_DITH_PER: rmux = dith_per;
			`SCPC_ADR_RED_TIME: rmux = red_time;
			`SCPC_ADR_RED_PCT:  rmux = red_pct;
			`SCPC_ADR_CMD:      rmux = cmd_pm;
			`SCPC_ADR_TEMP:     rmux = {8'h00, temp_i};
			`SCPC_ADR_STATUS:   rmux = {9'h000, unlocked, link_on_o, reducing, short_err_o,
				error_o, state};
			`SCPC_ADR_LINK_TMO: rmux = link_tmo;
			`SCPC_ADR_ISENSE:   rmux = isense_i;
			default:            rmux = 16'h0000;
		endcase
	end
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
			rdata_o <= 16'h0000;
		else if (bus_i.rd)
			rdata_o <= rmux;
		else
			rdata_o <= 16'h0000;
	end
endmodule : scpc_core

// [scpc_core_asserts.sv]
// Port checker for the solenoid current controller.
`timescale 1ns/1ps
module scpc_core_asserts #(
	parameter int PWM_PERIOD = 100
) (
	input wire logic                clk_i,
	input wire logic                nrst_i,
	input wire scpc_pkg::scpc_bus_t bus_i,
	input wire logic [15:0]         rdata_o,
	input wire logic [7:0]          temp_i,
	input wire logic [15:0]         isense_i,
	input wire logic                button_i,
	input wire logic                link_activity_i,
	input wire logic                nv_we_o,
	input wire logic                pwm_o,
	input wire logic                link_on_o,
	input wire logic                error_o,
	input wire logic                short_err_o
);
	logic [15:0] phase;
	logic        rose_once;
	logic [2:0]  ack_age;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	////////////////////////////////////////////////////////////
	// The phase wraps at one period, so a skipped pulse still lands on a whole period.
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			phase     <= 16'h0000;
			rose_once <= 1'b0;
			ack_age   <= 3'h0;
		end
		else
		begin
			phase     <= (pwm_o && !$past(pwm_o)) || phase == PWM_PERIOD ? 16'h0001 : phase + 16'h0001;
			rose_once <= rose_once || (pwm_o && !$past(pwm_o));
			ack_age   <= bus_i.wr && bus_i.addr == 4'hD ? 3'h7 : ack_age - {2'h0, ack_age != 3'h0};
		end
	end
	////////////////////////////////////////////////////////////
	carrier_period_a : assert property ($rose(pwm_o) && rose_once |-> phase == PWM_PERIOD)
		else $error("carrier period wrong");
	hot_error_a : assert property ($rose(temp_i > 8'h5A) |-> ##[1:300] error_o)
		else $error("no error on over-temperature");
	hot_block_a : assert property (error_o && $past(error_o) |-> !pwm_o)
		else $error("output driven in error");
	over_cur_a : assert property ($rose(isense_i > 16'h09C4) |-> ##[1:300] short_err_o)
		else $error("overcurrent missed");
	ack_needed_a : assert property ($fell(error_o) |-> ack_age != 3'h0 && temp_i <= 8'h5A)
		else $error("error cleared without ack or hot");
	pwd_hidden_a : assert property ($past(bus_i.rd) && $past(bus_i.addr) == 4'hA |-> rdata_o == 16'h0000)
		else $error("password readable");
	nv_store_a : assert property (nv_we_o |-> $past(bus_i.wr))
		else $error("store write without bus write");
	button_link_a : assert property ($rose(button_i) |-> ##[1:6] link_on_o)
		else $error("button did not open link");
	idle_off_a : assert property ($fell(link_on_o) |-> !$past(link_activity_i))
		else $error("link closed while active");
endmodule : scpc_core_asserts

// [scpc_map.svh]
// Register offsets, field positions, reset values and timing counts of the solenoid controller.
`ifndef SCPC_MAP_SVH
`define SCPC_MAP_SVH
`define SCPC_CLK_HZ          10000000
`define SCPC_PWM_HZ          1000
`define SCPC_PWM_PERIOD      (`SCPC_CLK_HZ / `SCPC_PWM_HZ)
`define SCPC_ADR_CTRL        4'h0
`define SCPC_ADR_IMIN        4'h1
`define SCPC_ADR_IMAX        4'h2
`define SCPC_ADR_DITH_AMP    4'h3
`define SCPC_ADR_DITH_PER    4'h4
`define SCPC_ADR_RED_TIME    4'h5
`define SCPC_ADR_RED_PCT     4'h6
`define SCPC_ADR_CMD         4'h7
`define SCPC_ADR_TEMP        4'h8
`define SCPC_ADR_STATUS      4'h9
`define SCPC_ADR_PASSWORD    4'hA
`define SCPC_ADR_UNLOCK      4'hB
`define SCPC_ADR_LINK_TMO    4'hC
`define SCPC_ADR_ACK         4'hD
`define SCPC_ADR_ISENSE      4'hE
`define SCPC_CTRL_SRC_LSB    0
`define SCPC_CTRL_SWITCHING  3
`define SCPC_CTRL_BUS_VAR    4
`define SCPC_CTRL_BUS_EN     5
`define SCPC_CTRL_PWM_MODE   6
`define SCPC_CTRL_PRED_EN    7
`define SCPC_RST_IMIN        16'h0032
`define SCPC_RST_IMAX        16'h02BC
`define SCPC_RST_DITH_AMP    16'h00B4
`define SCPC_RST_DITH_PER    16'h000C
`define SCPC_RST_RED_TIME    16'h0064
`define SCPC_RST_RED_PCT     16'h0032
`define SCPC_RST_LINK_TMO    16'h012C
`define SCPC_T_DERATE        8'h50
`define SCPC_T_ERROR         8'h5A
`define SCPC_I_ABS_MAX       16'h09C4
`define SCPC_DERATE_MA_PER_C 16'h0064
`endif

// [scpc_pkg.sv]
// Types shared by the solenoid controller.
package scpc_pkg;
	typedef enum logic [2:0] {
		SRC_VOLT = 3'b000,
		SRC_CURR = 3'b001,
		SRC_DIG  = 3'b010,
		SRC_FREQ = 3'b011,
		SRC_PWM  = 3'b100,
		SRC_BUS  = 3'b101
	} scpc_src_t;
	typedef enum logic [1:0] {
		ST_OFF   = 2'b00,
		ST_RUN   = 2'b01,
		ST_ERROR = 2'b10
	} scpc_state_t;
	typedef struct packed {
		logic [3:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} scpc_bus_t;
	typedef struct packed {
		logic [11:0] adc;
		logic [15:0] freq;
		logic [15:0] duty;
		logic [15:0] bus_val;
	} scpc_cmd_in_t;
endpackage : scpc_pkg

// [test_solenoid_current_pwm_control.sv]
// Self-checking bench for the solenoid current controller.
`timescale 1ns/1ps
`include "scpc_map.svh"
module test_solenoid_current_pwm_control;
	localparam int P = 100;
	logic                   clk_i;
	logic                   nrst_i;
	scpc_pkg::scpc_bus_t    bus_i;
	scpc_pkg::scpc_cmd_in_t cmd_i;
	logic [15:0]            rdata_o;
	logic [15:0]            isense_i;
	logic [15:0]            nv_rdata;
	logic [15:0]            nv_wdata;
	logic                   nv_we;
	logic [7:0]             temp_i;
	logic [3:0]             nv_addr;
	logic [1:0]             gain;
	logic                   en, btn, act, shrt;
	logic                   pwm_o, link_on_o, error_o, short_err_o;
	int                     failures, tests_run, cycles;
	// The store holds the defaults; what it returns must come back after reset.
	logic [15:0] nv_tab [16] = '{16'h0000, `SCPC_RST_IMIN, `SCPC_RST_IMAX, `SCPC_RST_DITH_AMP,
		`SCPC_RST_DITH_PER, `SCPC_RST_RED_TIME, `SCPC_RST_RED_PCT, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h0000, `SCPC_RST_LINK_TMO, 16'h0000, 16'h0000, 16'h0000};
	assign nv_rdata = nv_tab[nv_addr];
	scpc_core #(.PWM_PERIOD(P), .MS_TICKS(10)) dut_u (.clk_i(clk_i), .nrst_i(nrst_i),
		.bus_i(bus_i), .rdata_o(rdata_o), .cmd_i(cmd_i), .temp_i(temp_i), .isense_i(isense_i),
		.enable_pin_i(en), .button_i(btn), .link_activity_i(act), .nv_valid_i(1'b1),
		.nv_rdata_i(nv_rdata), .nv_addr_o(nv_addr), .nv_wdata_o(nv_wdata), .nv_we_o(nv_we),
		.pwm_o(pwm_o),
		.link_on_o(link_on_o), .error_o(error_o), .short_err_o(short_err_o));
	scpc_coil_model #(.PERIOD(P)) coil_u (.clk_i(clk_i), .pwm_i(pwm_o), .gain_i(gain),
		.short_i(shrt), .isense_o(isense_i));
	////////////////////////////////////////////////////////////
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask : cyc
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk_i);
		bus_i <= '{a, v, 1'b1, 1'b0};
		@(posedge clk_i);
		bus_i <= '0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [15:0] v);
		@(posedge clk_i);
		bus_i <= '{a, 16'h0000, 1'b0, 1'b1};
		@(posedge clk_i);
		bus_i <= '0;
		#1;
		v = rdata_o;
	endtask : rd
	task automatic chk(input logic [15:0] g, input logic [15:0] x, input string m);
		tests_run++;
		if (g !== x)
		begin
			failures++;
			$display("BAD %0t %s got %h exp %h", $time, m, g, x);
		end
	endtask : chk
	task automatic near(input logic [15:0] g, input logic [15:0] lo, input logic [15:0] hi,
		input string m);
		tests_run++;
		if ((g >= lo && g <= hi) !== 1'b1)
		begin
			failures++;
			$display("BAD %0t %s got %h", $time, m, g);
		end
	endtask : near
	task automatic duty(output logic [15:0] h);
		h = 16'h0000;
		repeat (P)
		begin
			@(posedge clk_i);
			#1;
			h = h + {15'h0000, pwm_o};
		end
	endtask : duty
	task automatic avgi(output logic [15:0] a);
		logic [31:0] s;
		s = 32'h0;
		repeat (24)
		begin
			cyc(P);
			s = s + isense_i;
		end
		a = 16'(s / 24);
	endtask : avgi
	////////////////////////////////////////////////////////////
	task automatic t_reset;
		logic [15:0] v;
		chk(link_on_o, 16'h0001, "link at power-up");
		for (int i = 0; i < 16; i++)
		begin
			if (!(i inside {7, 8, 9, 11, 13, 14}))
			begin
				rd(4'(i), v);
				chk(v, nv_tab[i], "restored value");
			end
		end
		$display("test reset done");
	endtask : t_reset
	task automatic t_src;
		logic [15:0] v;
		for (int s = 0; s < 6; s++)
		begin
			wr(4'h0, 16'(s));
			cmd_i <= '{12'hFFF, 16'h1388, 16'hFFFF, 16'hFFFF};
			cyc(3 * P);
			rd(4'h7, v);
			chk(v, 16'h03E8, "full command");
			cmd_i <= '0;
			cyc(3 * P);
			rd(4'h7, v);
			chk(v, 16'h0000, "zero command");
		end
		wr(4'h0, 16'h0000);
		cmd_i <= '{12'h800, 16'h0000, 16'h0000, 16'h0000};
		cyc(3 * P);
		rd(4'h7, v);
		chk(v, 16'h01F4, "mid-scale adc");
		$display("test source done");
	endtask : t_src
	task automatic t_reg;
		logic [15:0] v;
		en <= 1'b0;
		wr(4'h0, 16'h0080);
		cmd_i <= '{12'hFFF, 16'h0000, 16'h0000, 16'h0000};
		en <= 1'b1;
		cyc(45 * P);
		avgi(v);
		near(v, 16'h0280, 16'h02F8, "imax current");
		cmd_i <= '0;
		cyc(40 * P);
		avgi(v);
		near(v, 16'h000A, 16'h005A, "imin current");
		cmd_i <= '{12'hFFF, 16'h0000, 16'h0000, 16'h0000};
		temp_i <= 8'h55;
		cyc(40 * P);
		avgi(v);
		near(v, 16'h008C, 16'h0104, "derated current");
		$display("test regulation done");
	endtask : t_reg
	task automatic t_hot;
		logic [15:0] v;
		temp_i <= 8'h5B;
		cyc(3 * P);
		chk(error_o, 16'h0001, "hot error");
		duty(v);
		chk(v, 16'h0000, "blocked output");
		wr(4'hD, 16'h0001);
		cyc(10);
		chk(error_o, 16'h0001, "ack while hot");
		temp_i <= 8'h46;
		cyc(2 * P);
		chk(error_o, 16'h0001, "cool without ack");
		wr(4'hD, 16'h0001);
		cyc(3 * P);
		chk(error_o, 16'h0000, "ack when cool");
		duty(v);
		near(v, 16'h0001, 16'(P), "runs again");
		$display("test temperature done");
	endtask : t_hot
	task automatic t_red;
		logic [15:0] d, e, f;
		en <= 1'b0;
		wr(4'h0, 16'h0088);
		en <= 1'b1;
		cyc(3 * P);
		duty(d);
		near(d, 16'h0002, 16'(P), "full pull-in");
		cyc(12 * P);
		duty(e);
		near(e, d / 16'h0002 - 16'h0001, d / 16'h0002 + 16'h0001, "half hold");
		gain <= 2'h2;
		cyc(2 * P);
		duty(f);
		chk(f, e, "open loop");
		wr(4'h3, 16'h00FA);
		d = 16'hFFFF;
		e = 16'h0000;
		repeat (24)
		begin
			duty(f);
			d = (f < d) ? f : d;
			e = (f > e) ? f : e;
		end
		chk(d, 16'h0004, "dither low");
		chk(e, 16'h0018, "dither high");
		wr(4'h3, 16'h0000);
		gain <= 2'h1;
		$display("test reduction done");
	endtask : t_red
	task automatic t_short;
		shrt <= 1'b1;
		cyc(3 * P);
		chk(short_err_o, 16'h0001, "overcurrent");
		shrt <= 1'b0;
		cyc(2 * P);
		wr(4'hD, 16'h0001);
		cyc(3 * P);
		chk(short_err_o, 16'h0000, "overcurrent cleared");
		$display("test short done");
	endtask : t_short
	task automatic t_en;
		logic [15:0] d;
		wr(4'h0, 16'h0008);
		en <= 1'b0;
		cyc(3 * P);
		duty(d);
		chk(d, 16'h0000, "pin low");
		en <= 1'b1;
		cyc(3 * P);
		duty(d);
		near(d, 16'h0001, 16'(P), "pin high");
		wr(4'h0, 16'h0018);
		cyc(3 * P);
		duty(d);
		chk(d, 16'h0000, "bus not enabled");
		wr(4'h0, 16'h0038);
		cyc(3 * P);
		duty(d);
		near(d, 16'h0001, 16'(P), "bus enabled");
		cmd_i <= '{12'h800, 16'h0000, 16'h0000, 16'h0000};
		wr(4'h0, 16'h0078);
		cyc(3 * P);
		duty(d);
		chk(d, 16'(P / 2), "pulse-width mode");
		$display("test enable done");
	endtask : t_en
	task automatic t_link;
		logic [15:0] v;
		wr(4'hA, 16'h1234);
		#1;
		chk(nv_we, 16'h0001, "store written");
		chk(nv_wdata, 16'h1234, "store data");
		wr(4'h1, 16'h0040);
		#1;
		chk(nv_we, 16'h0000, "locked not stored");
		rd(4'h1, v);
		chk(v, `SCPC_RST_IMIN, "locked write");
		rd(4'h2, v);
		chk(v, `SCPC_RST_IMAX, "locked read");
		rd(4'hA, v);
		chk(v, 16'h0000, "password hidden");
		wr(4'hB, 16'h1234);
		wr(4'h1, 16'h0040);
		rd(4'h1, v);
		chk(v, 16'h0040, "unlocked write");
		act <= 1'b0;
		cyc(2900);
		chk(link_on_o, 16'h0001, "link before idle time");
		cyc(200);
		chk(link_on_o, 16'h0000, "link after idle time");
		wr(4'h1, 16'h0050);
		rd(4'h1, v);
		chk(v, 16'h0040, "relocked");
		btn <= 1'b1;
		cyc(6);
		chk(link_on_o, 16'h0001, "button opens link");
		btn <= 1'b0;
		act <= 1'b1;
		$display("test link done");
	endtask : t_link
	task automatic summarize;
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : summarize
	////////////////////////////////////////////////////////////
	initial
	begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			failures++;
			$display("BAD %0t timeout", $time);
			summarize();
		end
	end
	initial
	begin
		nrst_i = 1'b0;
		bus_i = '0;
		cmd_i = '0;
		temp_i = 8'h19;
		{en, btn, shrt} = 3'h0;
		act = 1'b1;
		gain = 2'h1;
		cyc(12);
		nrst_i <= 1'b1;
		cyc(40);
		t_reset();
		wr(4'h3, 16'h0000);
		t_src();
		t_reg();
		t_hot();
		t_red();
		t_short();
		t_en();
		t_link();
		summarize();
	end
endmodule : test_solenoid_current_pwm_control
bind scpc_core scpc_core_asserts #(.PWM_PERIOD(PWM_PERIOD)) chk_u (.clk_i(clk_i),
	.nrst_i(nrst_i), .bus_i(bus_i), .rdata_o(rdata_o), .temp_i(temp_i), .isense_i(isense_i),
	.button_i(button_i), .link_activity_i(link_activity_i), .nv_we_o(nv_we_o), .pwm_o(pwm_o),
	.link_on_o(link_on_o), .error_o(error_o), .short_err_o(short_err_o));
